//--- bench/cms_top_bench.sv
`timescale 1ns/1ns
`include "cms_map.svh"
// ==================================================
// compare helper
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module cms_top_bench;
   // ==================================================
   // stimulus and observed signals
   logic mclk, resetn, irq_clr, slow_tick, ext_pin, addr_trap_req, wdt_req, tick_en;
   cms_pkg::cms_wr_s sw;
   logic rst_pin_in, rst_pin_out, rst_pin_oe_n, sys_rst_n, clk_fast, cpu_clk_en;
   logic warmup_done_irq, irq_latch, master_irq_enable, individual_irq_enable, wdt_enable;
   logic [7:0] sc2_q, tdiv_cnt;
   logic [15:0] pc_vector, cmp;
   cms_pkg::cms_mode_e run_mode;
   logic [31:0] seed;
   int failures, samples_checked, n, p, tphase, lowrun, lastrun;

   cms_top u_dut (.mclk(mclk), .resetn(resetn), .sw(sw), .irq_clr(irq_clr), .slow_tick(slow_tick),
      .rst_pin_in(rst_pin_in), .addr_trap_req(addr_trap_req), .wdt_req(wdt_req),
      .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n), .sys_rst_n(sys_rst_n), .sc2_q(sc2_q),
      .clk_fast(clk_fast), .cpu_clk_en(cpu_clk_en), .run_mode(run_mode),
      .warmup_done_irq(warmup_done_irq), .irq_latch(irq_latch), .master_irq_enable(master_irq_enable),
      .individual_irq_enable(individual_irq_enable), .pc_vector(pc_vector), .wdt_enable(wdt_enable),
      .tdiv_cnt(tdiv_cnt));

   // wire level: device pull-down wins while it drives, else the external side
   assign rst_pin_in = rst_pin_oe_n ? ext_pin : rst_pin_out;

   // ==================================================
   // clock, slow clock ticks, reset pulse length monitor
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // one tick every five cycles while enabled
   always @(posedge mclk) begin
      tphase <= (tphase + 1) % 5;
      slow_tick <= #1 (tick_en && tphase == 4);
   end

   // length of the last internal reset pulse in cycles
   always @(posedge mclk) begin
      if (sys_rst_n === 1'b0) begin
         lowrun <= lowrun + 1;
      end else if (lowrun != 0) begin
         lastrun <= lowrun;
         lowrun <= 0;
      end
   end

   // ==================================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task print_verdict;
      if (failures == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task step;
      @(posedge mclk);
      #1;
   endtask

   // one write strobe (0 sc2, 1 ltc, 2 utc, 3 cmp low, 4 cmp high, 5 enables), then a idle cycle
   task automatic wr(input int k, input logic [7:0] d);
      sw = cms_pkg::cms_wr_s'({6'b100000 >> k, d});
      step();
      sw = '0;
      step();
   endtask

   // bounded wait for a level, cycles spent left in n
   task automatic wt(ref logic s, input logic v, input int lim);
      n = 0;
      while (s !== v) begin
         step();
         n++;
         if (n > lim) begin
            failures++;
            print_verdict();
         end
      end
   endtask

   // ==================================================
   // main sequence
   initial begin
      seed = 32'h0DBB;
      failures = 0;
      samples_checked = 0;
      tphase = 0;
      lowrun = 0;
      lastrun = 0;
      tick_en = 1'b1;
      ext_pin = 1'b1;
      resetn = 1'b0;
      irq_clr = 1'b0;
      slow_tick = 1'b0;
      addr_trap_req = 1'b0;
      wdt_req = 1'b0;
      sw = '0;
      repeat (12) step();
      // values held while reset is applied
      `CHK(sc2_q, 8'h80)
      `CHK({pc_vector, wdt_enable, tdiv_cnt}, {`CMS_RESET_VEC, 1'b1, 8'h00})
      `CHK({master_irq_enable, individual_irq_enable, irq_latch}, 3'b000)
      `CHK({rst_pin_oe_n, rst_pin_out, sys_rst_n}, 3'b000)
      resetn = 1'b1;
      wt(sys_rst_n, 1'b1, 40);
      `CHK(n > 0 && n <= `CMS_MALF_CYC, 1'b1)
      `CHK({run_mode, cpu_clk_en}, {cms_pkg::fast_only_run, 1'b1})
      // address trap, watchdog, clock fault (fast enable dropped while fast selected)
      for (int i = 0; i < 3; i++) begin
         addr_trap_req = (i == 0);
         wdt_req = (i == 1);
         if (i == 2) wr(0, 8'h00);
         else step();
         addr_trap_req = 1'b0;
         wdt_req = 1'b0;
         wt(sys_rst_n, 1'b0, 4);
         `CHK({rst_pin_oe_n, rst_pin_out}, 2'b00)
         wt(sys_rst_n, 1'b1, 40);
         step();
         `CHK(lastrun, `CMS_MALF_CYC)
         `CHK(sc2_q, 8'h80)
      end
      // slow warm-up on slow ticks, then fast warm-up on every cycle
      wr(0, 8'hC0);
      wr(5, 8'h03);
      for (int m = 0; m < 2; m++) begin
         p = m ? 1 : 5;
         seed = lfsr(seed);
         cmp = {11'h000, seed[4:0]} + 16'h0002;
         wr(1, m ? `CMS_LTC_FAST : `CMS_LTC_SLOW);
         wr(3, cmp[7:0]);
         wr(4, cmp[15:8]);
         wr(2, `CMS_UTC_WARMUP | 8'h08);
         wt(irq_latch, 1'b1, 400);
         `CHK(n >= p * cmp - 1 && n <= p * cmp + p + 3, 1'b1)
         `CHK(warmup_done_irq, 1'b1)
         irq_clr = 1'b1;
         step();
         irq_clr = 1'b0;
         repeat (2 * p * cmp + 10) step();
         `CHK(irq_latch, 1'b0)
         wr(2, `CMS_UTC_WARMUP);
         if (m == 0) begin
            wr(0, 8'hE0);
            wt(clk_fast, 1'b0, 20);
            `CHK(run_mode, cms_pkg::slow_dual_osc_run)
            wr(0, 8'h60);
            `CHK({run_mode, sys_rst_n}, {cms_pkg::slow_only_run, 1'b1})
            wr(0, 8'hE0);
         end
      end
      // select cleared while ticks are held off: stay on slow clock
      tick_en = 1'b0;
      wr(0, 8'hC0);
      repeat (3) step();
      `CHK(clk_fast, 1'b0)
      tick_en = 1'b1;
      wt(clk_fast, 1'b1, 20);
      `CHK(run_mode, cms_pkg::fast_dual_osc_run)
      // pin held low too briefly, then long enough, from slow mode
      wr(0, 8'hE0);
      wt(clk_fast, 1'b0, 20);
      for (int k = 11; k <= 14; k += 3) begin
         ext_pin = 1'b0;
         repeat (k) step();
         `CHK(sys_rst_n, (k > `CMS_PIN_CYC) ? 1'b0 : 1'b1)
         ext_pin = 1'b1;
         step();
         wt(sys_rst_n, 1'b1, 10);
      end
      `CHK({run_mode, clk_fast, sc2_q}, {cms_pkg::fast_only_run, 1'b1, 8'h80})
      print_verdict();
   end
endmodule

//--- rtl/cms_map.svh
`ifndef CMS_MAP_SVH
`define CMS_MAP_SVH

// ==================================================
// clock and timing
`define CMS_CLK_NS 40
`define CMS_FC_NS 40
`define CMS_MALF_FC 24
`define CMS_MALF_CYC ((`CMS_MALF_FC * `CMS_FC_NS) / `CMS_CLK_NS)
`define CMS_PIN_FC 12
`define CMS_PIN_CYC ((`CMS_PIN_FC * `CMS_FC_NS + `CMS_CLK_NS - 1) / `CMS_CLK_NS)

// ==================================================
// system control two fields
`define CMS_SC2_FAST_EN 7
`define CMS_SC2_SLOW_EN 6
`define CMS_SC2_CLK_SEL 5
`define CMS_SC2_RST 8'h80
`define CMS_SC2_WMASK 8'hE0

// ==================================================
// timer controls and reset values
`define CMS_UTC_START 3
`define CMS_UTC_WARMUP 8'h05
`define CMS_LTC_SLOW 8'h43
`define CMS_LTC_FAST 8'h63
`define CMS_RESET_VEC 16'hFFFE
`endif

//--- rtl/cms_pkg.sv
package cms_pkg;
   // ==================================================
   // run modes
   typedef enum logic [1:0] {
      fast_only_run = 2'b00,
      fast_dual_osc_run = 2'b01,
      slow_dual_osc_run = 2'b10,
      slow_only_run = 2'b11
   } cms_mode_e;

   // ==================================================
   // software write strobes with shared data
   typedef struct packed {
      logic sc2_wr;
      logic ltc_wr;
      logic utc_wr;
      logic cmpl_wr;
      logic cmph_wr;
      logic ie_wr;
      logic [7:0] data;
   } cms_wr_s;

   // ==================================================
   // warm-up counter state
   typedef struct packed {
      logic [15:0] cnt;
      logic fired;
      logic done;
   } cms_wu_s;

   // ==================================================
   // top state
   typedef struct packed {
      logic [7:0] sc2;
      logic cur_fast;
      logic cpu_en;
      cms_mode_e mode;
      logic [4:0] malf_cnt;
      logic [3:0] pin_cnt;
      logic sys_rst;
      logic pin_oe_n;
      logic pin_out;
      logic ime;
      logic ief;
      logic il;
      logic irq;
      logic [7:0] ltc;
      logic [7:0] utc;
      logic [15:0] cmp;
      logic [7:0] tdiv;
      logic wdt_en;
      logic [15:0] pc_vec;
      logic [5:0] low_run;
   } cms_top_s;
endpackage

//--- rtl/cms_top.sv
`timescale 1ns/1ns
`include "cms_map.svh"
module cms_top (
   input wire logic mclk, // system clock, fast clock
   input wire logic resetn, // power-on reset, low
   input wire cms_pkg::cms_wr_s sw, // software writes
   input wire logic irq_clr, // clear warm-up latch
   input wire logic slow_tick, // slow clock enable pulse
   input wire logic rst_pin_in, // reset pin level
   input wire logic addr_trap_req, // address trap request
   input wire logic wdt_req, // watchdog request
   output logic rst_pin_out, // reset pin drive level
   output logic rst_pin_oe_n, // reset pin enable, low
   output logic sys_rst_n, // internal reset, low
   output logic [7:0] sc2_q, // system control two
   output logic clk_fast, // fast clock in use
   output logic cpu_clk_en, // cpu clock enable
   output cms_pkg::cms_mode_e run_mode, // run mode
   output logic warmup_done_irq, // gated warm-up request
   output logic irq_latch, // warm-up latch
   output logic master_irq_enable, // master enable
   output logic individual_irq_enable, // warm-up enable
   output logic [15:0] pc_vector, // reset vector
   output logic wdt_enable, // watchdog enabled
   output logic [7:0] tdiv_cnt // timing divider
);
   cms_pkg::cms_top_s r;
   cms_pkg::cms_top_s n;
   logic wu_done;
   logic xen_cl;
   logic xten_cl;
   logic sel_new;
   logic clk_fault;
   logic malf_req;
   logic pin_low;
   logic ext_rst;
   logic [3:0] chk_low;

   // ==================================================
   // warm-up counter
   cms_warmup u_wu (
      .mclk(mclk),
      .resetn(resetn),
      .clr(r.sys_rst),
      .ltc(r.ltc),
      .utc(r.utc),
      .cmp(r.cmp),
      .slow_tick(slow_tick),
      .done(wu_done)
   );

   // ==================================================
   // next-state logic
   always_comb begin
      n = r;
      // illegal oscillator clears
      xen_cl = r.sc2[`CMS_SC2_FAST_EN] & ~sw.data[`CMS_SC2_FAST_EN];
      xten_cl = r.sc2[`CMS_SC2_SLOW_EN] & ~sw.data[`CMS_SC2_SLOW_EN];
      sel_new = sw.data[`CMS_SC2_CLK_SEL];
      clk_fault = sw.sc2_wr & ~r.sys_rst & ((xen_cl & xten_cl) | (xen_cl & ~sel_new) | (xten_cl & sel_new));
      malf_req = addr_trap_req | wdt_req | clk_fault;
      // reset pin filter, ignores own drive
      pin_low = ~rst_pin_in & r.pin_oe_n;
      if (pin_low) begin
         if (r.pin_cnt != 4'(`CMS_PIN_CYC)) begin
            n.pin_cnt = r.pin_cnt + 4'h1;
         end
      end else begin
         n.pin_cnt = 4'h0;
      end
      ext_rst = pin_low && (n.pin_cnt == 4'(`CMS_PIN_CYC));
      // malfunction stretch, no retrigger while running
      if (r.malf_cnt != 5'h00) begin
         n.malf_cnt = r.malf_cnt - 5'h01;
      end else if (malf_req) begin
         n.malf_cnt = 5'(`CMS_MALF_CYC);
      end
      n.pin_oe_n = (n.malf_cnt == 5'h00);
      n.pin_out = 1'b0;
      n.sys_rst = ext_rst | ~n.pin_oe_n;
      n.low_run = n.pin_oe_n ? 6'h00 : ((r.low_run == 6'h3F) ? r.low_run : r.low_run + 6'h01);
      n.tdiv = r.tdiv + 8'h01;
      if (r.sys_rst) begin
         // reset-initialised state
         n.sc2 = `CMS_SC2_RST;
         n.cur_fast = 1'b1;
         n.ltc = 8'h00;
         n.utc = 8'h00;
         n.cmp = 16'h0000;
         n.ime = 1'b0;
         n.ief = 1'b0;
         n.il = 1'b0;
         n.tdiv = 8'h00;
         n.wdt_en = 1'b1;
         n.pc_vec = `CMS_RESET_VEC;
      end else begin
         // software writes; a faulting write is not stored
         if (sw.sc2_wr && !clk_fault) begin
            n.sc2 = sw.data & `CMS_SC2_WMASK;
         end
         if (sw.ltc_wr) begin
            n.ltc = sw.data;
         end
         if (sw.utc_wr) begin
            n.utc = sw.data;
         end
         if (sw.cmpl_wr) begin
            n.cmp[7:0] = sw.data;
         end
         if (sw.cmph_wr) begin
            n.cmp[15:8] = sw.data;
         end
         if (sw.ie_wr) begin
            n.ime = sw.data[0];
            n.ief = sw.data[1];
         end
         // latch: set beats clear
         if (irq_clr) begin
            n.il = 1'b0;
         end
         if (wu_done) begin
            n.il = 1'b1;
         end
         // clock changeover only on a slow clock edge
         if (slow_tick) begin
            if (r.sc2[`CMS_SC2_CLK_SEL] && r.cur_fast) begin
               n.cur_fast = 1'b0;
            end else if (!r.sc2[`CMS_SC2_CLK_SEL] && !r.cur_fast) begin
               n.cur_fast = 1'b1;
            end
         end
      end
      n.cpu_en = n.cur_fast | slow_tick;
      // run mode from clock in use and oscillators
      case ({n.cur_fast, n.sc2[`CMS_SC2_SLOW_EN], n.sc2[`CMS_SC2_FAST_EN]})
         3'b100, 3'b101: n.mode = cms_pkg::fast_only_run;
         3'b110, 3'b111: n.mode = cms_pkg::fast_dual_osc_run;
         3'b001, 3'b011: n.mode = cms_pkg::slow_dual_osc_run;
         default: n.mode = cms_pkg::slow_only_run;
      endcase
      n.irq = n.il & n.ime & n.ief;
   end

   // ==================================================
   // state register; power-on leaves one malfunction pulse
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
         r.malf_cnt <= 5'(`CMS_MALF_CYC);
         r.sys_rst <= 1'b1;
         r.low_run <= 6'h01;
         r.sc2 <= `CMS_SC2_RST;
         r.cur_fast <= 1'b1;
         r.cpu_en <= 1'b1;
         r.wdt_en <= 1'b1;
         r.pc_vec <= `CMS_RESET_VEC;
      end else begin
         r <= n;
      end
   end

   // outputs straight from state
   assign rst_pin_out = r.pin_out;
   assign rst_pin_oe_n = r.pin_oe_n;
   assign sys_rst_n = ~r.sys_rst;
   assign sc2_q = r.sc2;
   assign clk_fast = r.cur_fast;
   assign cpu_clk_en = r.cpu_en;
   assign run_mode = r.mode;
   assign warmup_done_irq = r.irq;
   assign irq_latch = r.il;
   assign master_irq_enable = r.ime;
   assign individual_irq_enable = r.ief;
   assign pc_vector = r.pc_vec;
   assign wdt_enable = r.wdt_en;
   assign tdiv_cnt = r.tdiv;

   // ==================================================
   // checks
   a_malf_stretch: assert property (@(posedge mclk) disable iff (!resetn)
      (malf_req && r.malf_cnt == 5'h00) |=> (!rst_pin_oe_n && !sys_rst_n) [*8] ##16 !rst_pin_oe_n)
      else $error("malfunction reset shorter than 24 cycles");
   a_malf_bound: assert property (@(posedge mclk) disable iff (!resetn)
      r.low_run <= 6'h18) else $error("reset pin driven low over 24 cycles");
   a_pin_low: assert property (@(posedge mclk) disable iff (!resetn)
      !rst_pin_oe_n |-> (!rst_pin_out && !sys_rst_n)) else $error("pin driven without internal reset");
   a_clk_fault: assert property (@(posedge mclk) disable iff (!resetn)
      (clk_fault && r.malf_cnt == 5'h00) |=> (!rst_pin_oe_n && sc2_q == $past(sc2_q)))
      else $error("oscillator fault did not reset");

   // check helper: cycles of undriven low pin already seen, held at eleven
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         chk_low <= 4'h0;
      end else if (!rst_pin_in && rst_pin_oe_n) begin
         chk_low <= (chk_low == 4'hB) ? chk_low : chk_low + 4'h1;
      end else begin
         chk_low <= 4'h0;
      end
   end

   a_pin_filter: assert property (@(posedge mclk) disable iff (!resetn)
      (!rst_pin_in && rst_pin_oe_n && chk_low == 4'hB) |=> !sys_rst_n) else $error("pin reset not applied");
   a_cpu_clock: assert property (@(posedge mclk) disable iff (!resetn)
      !clk_fast |=> (clk_fast || cpu_clk_en == $past(slow_tick)))
      else $error("cpu clock not on slow ticks");
   a_sync_slow: assert property (@(posedge mclk) disable iff (!resetn)
      (sc2_q[`CMS_SC2_CLK_SEL] && clk_fast && slow_tick && sys_rst_n) |=> !clk_fast)
      else $error("slow clock not taken at sync");
   a_reset_init: assert property (@(posedge mclk) disable iff (!resetn)
      !sys_rst_n |=> (sc2_q == `CMS_SC2_RST && !irq_latch && !master_irq_enable && !individual_irq_enable
      && wdt_enable && pc_vector == `CMS_RESET_VEC && tdiv_cnt == 8'h00)) else $error("reset state wrong");
   a_mode_rst: assert property (@(posedge mclk) disable iff (!resetn)
      $rose(sys_rst_n) |-> (run_mode == cms_pkg::fast_only_run && clk_fast))
      else $error("not fast-only after reset");
   a_sync_hold: assert property (@(posedge mclk) disable iff (!resetn)
      (!sc2_q[`CMS_SC2_CLK_SEL] && !clk_fast && !slow_tick && sys_rst_n) |=> !clk_fast)
      else $error("fast clock taken before sync");
   a_sync_go: assert property (@(posedge mclk) disable iff (!resetn)
      (!sc2_q[`CMS_SC2_CLK_SEL] && !clk_fast && slow_tick && sys_rst_n) |=> clk_fast)
      else $error("fast clock not taken at sync");
   a_irq_set: assert property (@(posedge mclk) disable iff (!resetn)
      (wu_done && sys_rst_n) |=> irq_latch ##1 (irq_latch || $past(irq_clr)))
      else $error("warm-up latch not set");
endmodule

//--- rtl/cms_warmup.sv
`timescale 1ns/1ns
`include "cms_map.svh"
module cms_warmup (
   input wire logic mclk, // system clock
   input wire logic resetn, // async reset, low
   input wire logic clr, // internal reset clear
   input wire logic [7:0] ltc, // lower timer control
   input wire logic [7:0] utc, // upper timer control
   input wire logic [15:0] cmp, // cascaded compare
   input wire logic slow_tick, // slow clock enable
   output logic done // warm-up end pulse
);
   cms_pkg::cms_wu_s r;
   cms_pkg::cms_wu_s n;
   logic run;
   logic tick;

   // ==================================================
   // mode decode and counting
   always_comb begin
      n = r;
      n.done = 1'b0;
      run = utc[`CMS_UTC_START] && ({utc[7:4], 1'b0, utc[2:0]} == `CMS_UTC_WARMUP) &&
         (ltc == `CMS_LTC_SLOW || ltc == `CMS_LTC_FAST);
      tick = (ltc == `CMS_LTC_FAST) ? 1'b1 : slow_tick;
      if (clr || !run) begin
         n.cnt = 16'h0000;
         n.fired = 1'b0;
      end else if (tick && !r.fired) begin
         if (r.cnt == cmp) begin
            n.done = 1'b1;
            n.fired = 1'b1;
         end else begin
            n.cnt = r.cnt + 16'h0001;
         end
      end
   end

   // state register
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign done = r.done;

   // ==================================================
   // checks
   a_done_match: assert property (@(posedge mclk) disable iff (!resetn)
      done |-> (r.cnt == cmp && r.fired)) else $error("warm-up end without compare match");
   a_done_once: assert property (@(posedge mclk) disable iff (!resetn)
      done |=> !done [*8]) else $error("warm-up end pulse repeated");
   a_src_slow: assert property (@(posedge mclk) disable iff (!resetn)
      (run && !clr && ltc == `CMS_LTC_SLOW && !slow_tick) |=> r.cnt == $past(r.cnt))
      else $error("slow source counted without slow tick");
   a_mode_gate: assert property (@(posedge mclk) disable iff (!resetn)
      done |-> $past(run)) else $error("warm-up end outside warm-up mode");
endmodule
